/* File: design/cfb_pkg.sv */
package cfb_pkg;
   localparam int CFB_NUM_PAIRS = 8;
   localparam logic [7:0] CFB_ADDR_WRITE = 8'hDC;
   localparam logic [7:0] CFB_ADDR_READ = 8'hDD;
   localparam logic [7:0] CFB_OFS_CONTROL = 8'h00;
   localparam logic [7:0] CFB_OFS_ENABLE = 8'h01;
   localparam logic [7:0] CFB_OFS_STOP = 8'h02;
   localparam logic [7:0] CFB_OFS_SPARE = 8'h03;
   localparam logic [7:0] CFB_OFS_IDENT = 8'h04;
   localparam int CFB_BIT_PD_TRI = 7;
   localparam int CFB_BIT_HALT_TRI = 6;
   localparam int CFB_BIT_BW = 2;
   localparam int CFB_BIT_LOOP = 1;
   localparam int CFB_BIT_DIV = 0;
   localparam logic [7:0] CFB_RST_CONTROL = 8'h07;
   localparam logic [7:0] CFB_RST_ENABLE = 8'hFF;
   localparam logic [7:0] CFB_RST_STOP = 8'h00;
   localparam logic [7:0] CFB_RST_SPARE = 8'h00;
   localparam logic [7:0] CFB_READ_COUNT = 8'h08;
   // Identity value is arbitrary.
   localparam logic [7:0] CFB_IDENT_DEFAULT = 8'h3A;
   localparam int CFB_CLK_PERIOD_NS = 4;
   localparam int CFB_SCL_PERIOD_NS = 10000;
   localparam int CFB_QUARTER_CYCLES = CFB_SCL_PERIOD_NS / (4 * CFB_CLK_PERIOD_NS);
   typedef enum logic [2:0] {
      CFB_D_IDLE = 3'h0,
      CFB_D_RX = 3'h1,
      CFB_D_RXACK = 3'h3,
      CFB_D_TX = 3'h2,
      CFB_D_TXACK = 3'h6
   } cfb_dev_state_t;
   typedef enum logic [2:0] {
      CFB_K_ADDR = 3'h0,
      CFB_K_OFFSET = 3'h1,
      CFB_K_COUNT = 3'h3,
      CFB_K_DATA = 3'h2,
      CFB_K_RCOUNT = 3'h6,
      CFB_K_RDATA = 3'h7
   } cfb_kind_t;
   typedef enum logic [2:0] {
      CFB_H_IDLE = 3'h0,
      CFB_H_START = 3'h1,
      CFB_H_SEND = 3'h3,
      CFB_H_RECV = 3'h2,
      CFB_H_STOP = 3'h6
   } cfb_host_state_t;
endpackage

/* File: design/cfb_smbus_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface cfb_smbus_if;
   logic sclHostOut;
   logic sclHostOe;
   logic sdaHostOut;
   logic sdaHostOe;
   logic sdaDevOut;
   logic sdaDevOe;
   logic scl;
   logic sda;
   // Open-drain wires: a released line floats high through the pull-up.
   assign scl = sclHostOe ? sclHostOut : 1'b1;
   assign sda = (sdaHostOe ? sdaHostOut : 1'b1) & (sdaDevOe ? sdaDevOut : 1'b1);
   modport host (output sclHostOut, sclHostOe, sdaHostOut, sdaHostOe, input scl, sda);
   modport dev (output sdaDevOut, sdaDevOe, input scl, sda);
endinterface
`default_nettype wire

/* File: design/cfb_smbus_device.sv */
`timescale 1ns/100ps
`default_nettype none
module cfb_smbus_device import cfb_pkg::*; #(
   parameter int PAIRS = CFB_NUM_PAIRS,
   parameter logic [7:0] IDENT = CFB_IDENT_DEFAULT
) (
   input wire logic clk,
   input wire logic reset_n,
   cfb_smbus_if.dev bus,
   input wire logic [PAIRS-1:0] outputEnablePins,
   input wire logic enablePolarityStrap,
   input wire logic powerDownPin,
   input wire logic referenceHaltInput,
   input wire logic loopSelectPin,
   input wire logic loopBandwidthSelectN,
   input wire logic halveRateSelectN,
   input wire logic pllLockedIn,
   output logic [PAIRS-1:0] pairDrive,
   output logic [PAIRS-1:0] pairRun,
   output logic pllRun,
   output logic pllBandwidthLow,
   output logic halveRate,
   output logic clockDetectOn,
   output logic lockOut
);
   if (PAIRS < 1 || PAIRS > 8) begin
      $error("PAIRS must lie between 1 and 8");
   end
   logic sclPrev_q, sdaPrev_q;
   cfb_dev_state_t state_q, state_d;
   cfb_kind_t kind_q, kind_d;
   logic [3:0] bitCnt_q, bitCnt_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] ptr_q, ptr_d;
   logic [7:0] remain_q, remain_d;
   logic sdaLow_q, sdaLow_d;
   logic [7:0] ctrl_q, ctrl_d, enable_q, enable_d, halt_q, halt_d, spare_q, spare_d;
   logic sclRise, sclFall, startSeen, stopSeen;
   logic [7:0] rxByte, txByte;
   function automatic logic [7:0] readReg(input logic [7:0] ofs, input logic [7:0] c,
         input logic [7:0] e, input logic [7:0] h, input logic [7:0] s);
      case (ofs)
         CFB_OFS_CONTROL: readReg = c;
         CFB_OFS_ENABLE: readReg = e;
         CFB_OFS_STOP: readReg = h;
         CFB_OFS_SPARE: readReg = s;
         CFB_OFS_IDENT: readReg = IDENT;
         default: readReg = 8'h00;
      endcase
   endfunction
   assign sclRise = bus.scl & ~sclPrev_q;
   assign sclFall = ~bus.scl & sclPrev_q;
   assign startSeen = bus.scl & sclPrev_q & sdaPrev_q & ~bus.sda;
   assign stopSeen = bus.scl & sclPrev_q & ~sdaPrev_q & bus.sda;
   assign rxByte = {shift_q[6:0], bus.sda};
   assign txByte = readReg(ptr_q, ctrl_q, enable_q, halt_q, spare_q);
   always_comb begin
      state_d = state_q;
      kind_d = kind_q;
      bitCnt_d = bitCnt_q;
      shift_d = shift_q;
      ptr_d = ptr_q;
      remain_d = remain_q;
      sdaLow_d = sdaLow_q;
      ctrl_d = ctrl_q;
      enable_d = enable_q;
      halt_d = halt_q;
      spare_d = spare_q;
      if (stopSeen) begin
         state_d = CFB_D_IDLE;
         sdaLow_d = 1'b0;
      end else if (startSeen) begin
         state_d = CFB_D_RX;
         kind_d = CFB_K_ADDR;
         bitCnt_d = 4'h0;
         sdaLow_d = 1'b0;
      end else begin
         case (state_q)
            CFB_D_RX: begin
               if (sclRise && bitCnt_q < 4'h8) begin
                  shift_d = rxByte;
                  bitCnt_d = bitCnt_q + 4'h1;
                  if (bitCnt_q == 4'h7) begin
                     case (kind_q)
                        CFB_K_ADDR: begin
                           if (rxByte == CFB_ADDR_WRITE) begin
                              kind_d = CFB_K_OFFSET;
                           end else if (rxByte == CFB_ADDR_READ) begin
                              kind_d = CFB_K_RCOUNT;
                           end else begin
                              state_d = CFB_D_IDLE;
                           end
                        end
                        CFB_K_OFFSET: begin
                           ptr_d = rxByte;
                           kind_d = CFB_K_COUNT;
                        end
                        CFB_K_COUNT: begin
                           remain_d = rxByte;
                           kind_d = CFB_K_DATA;
                        end
                        CFB_K_DATA: begin
                           // A zero count is acknowledged but stores nothing.
                           if (remain_q != 8'h00) begin
                              remain_d = remain_q - 8'h01;
                              ptr_d = ptr_q + 8'h01;
                              case (ptr_q)
                                 CFB_OFS_CONTROL: ctrl_d = rxByte;
                                 CFB_OFS_ENABLE: enable_d = rxByte;
                                 CFB_OFS_STOP: halt_d = rxByte;
                                 CFB_OFS_SPARE: spare_d = rxByte;
                                 default: ;
                              endcase
                           end
                        end
                        default: ;
                     endcase
                  end
               end
               if (sclFall && bitCnt_q == 4'h8) begin
                  state_d = CFB_D_RXACK;
                  sdaLow_d = 1'b1;
                  bitCnt_d = 4'h0;
               end
            end
            CFB_D_RXACK: begin
               if (sclFall) begin
                  if (kind_q == CFB_K_RCOUNT) begin
                     state_d = CFB_D_TX;
                     kind_d = CFB_K_RDATA;
                     shift_d = CFB_READ_COUNT;
                     sdaLow_d = ~CFB_READ_COUNT[7];
                  end else begin
                     state_d = CFB_D_RX;
                     sdaLow_d = 1'b0;
                  end
               end
            end
            CFB_D_TX: begin
               if (sclRise) begin
                  bitCnt_d = bitCnt_q + 4'h1;
               end
               if (sclFall) begin
                  if (bitCnt_q == 4'h8) begin
                     state_d = CFB_D_TXACK;
                     sdaLow_d = 1'b0;
                     bitCnt_d = 4'h0;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     sdaLow_d = ~shift_q[6];
                  end
               end
            end
            CFB_D_TXACK: begin
               if (sclRise && bus.sda) begin
                  // A not-acknowledge ends the read; only start or stop follow.
                  state_d = CFB_D_IDLE;
               end else if (sclFall) begin
                  state_d = CFB_D_TX;
                  shift_d = txByte;
                  sdaLow_d = ~txByte[7];
                  ptr_d = ptr_q + 8'h01;
               end
            end
            default: ;
         endcase
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sclPrev_q <= 1'b1;
         sdaPrev_q <= 1'b1;
         state_q <= CFB_D_IDLE;
         kind_q <= CFB_K_ADDR;
         bitCnt_q <= 4'h0;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         remain_q <= 8'h00;
         sdaLow_q <= 1'b0;
         ctrl_q <= CFB_RST_CONTROL;
         enable_q <= CFB_RST_ENABLE;
         halt_q <= CFB_RST_STOP;
         spare_q <= CFB_RST_SPARE;
      end else begin
         sclPrev_q <= bus.scl;
         sdaPrev_q <= bus.sda;
         state_q <= state_d;
         kind_q <= kind_d;
         bitCnt_q <= bitCnt_d;
         shift_q <= shift_d;
         ptr_q <= ptr_d;
         remain_q <= remain_d;
         sdaLow_q <= sdaLow_d;
         ctrl_q <= ctrl_d;
         enable_q <= enable_d;
         halt_q <= halt_d;
         spare_q <= spare_d;
      end
   end
   assign bus.sdaDevOe = sdaLow_q;
   assign bus.sdaDevOut = 1'b0;
   logic [PAIRS-1:0] pairDrive_q, pairDrive_d, pairRun_q, pairRun_d;
   logic pllRun_q, pllRun_d, bwLow_q, bwLow_d, halve_q, halve_d, lock_q, lock_d;
   logic pdActive, haltActive, enActive;
   always_comb begin
      pdActive = powerDownPin ^ ~enablePolarityStrap;
      haltActive = referenceHaltInput ^ ~enablePolarityStrap;
      pllRun_d = loopSelectPin & ctrl_q[CFB_BIT_LOOP] & ~pdActive;
      bwLow_d = loopBandwidthSelectN & ctrl_q[CFB_BIT_BW];
      halve_d = ~(halveRateSelectN & ctrl_q[CFB_BIT_DIV]);
      lock_d = pllRun_d & pllLockedIn;
      for (int i = 0; i < PAIRS; i++) begin
         enActive = (outputEnablePins[i] ^ enablePolarityStrap) & enable_q[i];
         pairDrive_d[i] = enActive;
         pairRun_d[i] = enActive;
         if (pdActive) begin
            pairDrive_d[i] = enActive & ~ctrl_q[CFB_BIT_PD_TRI];
            pairRun_d[i] = 1'b0;
         end else if (haltActive && halt_q[i]) begin
            pairDrive_d[i] = enActive & ~ctrl_q[CFB_BIT_HALT_TRI];
            pairRun_d[i] = 1'b0;
         end
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pairDrive_q <= '0;
         pairRun_q <= '0;
         pllRun_q <= 1'b0;
         bwLow_q <= 1'b0;
         halve_q <= 1'b0;
         lock_q <= 1'b0;
      end else begin
         pairDrive_q <= pairDrive_d;
         pairRun_q <= pairRun_d;
         pllRun_q <= pllRun_d;
         bwLow_q <= bwLow_d;
         halve_q <= halve_d;
         lock_q <= lock_d;
      end
   end
   assign pairDrive = pairDrive_q;
   assign pairRun = pairRun_q;
   assign pllRun = pllRun_q;
   assign pllBandwidthLow = bwLow_q;
   assign halveRate = halve_q;
   // Clock detection only exists while the loop runs.
   assign clockDetectOn = pllRun_q;
   assign lockOut = lock_q;
endmodule
`default_nettype wire

/* File: design/cfb_smbus_host.sv */
`timescale 1ns/100ps
`default_nettype none
module cfb_smbus_host import cfb_pkg::*; #(
   parameter int QUARTER = CFB_QUARTER_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   cfb_smbus_if.host bus,
   input wire logic reqValid,
   input wire logic reqRead,
   input wire logic [7:0] reqOffset,
   input wire logic [7:0] reqCount,
   input wire logic [7:0] wrData,
   output logic reqReady,
   output logic wrTake,
   output logic [7:0] rdData,
   output logic rdValid,
   output logic [7:0] rdCountByte,
   output logic nackSeen,
   output logic done
);
   if (QUARTER < 2 || QUARTER > 65535) begin
      $error("QUARTER must lie between 2 and 65535");
   end

   cfb_host_state_t state_q, state_d;
   logic [15:0] div_q, div_d;
   logic [1:0] phase_q, phase_d, stage_q, stage_d;
   logic [3:0] bitNo_q, bitNo_d;
   logic [7:0] byte_q, byte_d, offset_q, offset_d, remain_q, remain_d;
   logic [7:0] rdData_q, rdData_d, rdCount_q, rdCount_d;
   logic read_q, read_d, sclLow_q, sclLow_d, sdaLow_q, sdaLow_d, ackBad_q, ackBad_d;
   logic wrTake_q, wrTake_d, rdValid_q, rdValid_d, nack_q, nack_d, done_q, done_d;
   logic tick, lastByte;
   logic ready_q, ready_d;

   assign tick = div_q == 16'(QUARTER - 1);
   assign lastByte = stage_q == 2'h3 && read_q && remain_q == 8'h01;

   always_comb begin
      state_d = state_q;
      div_d = tick ? 16'h0000 : div_q + 16'h0001;
      phase_d = phase_q;
      stage_d = stage_q;
      bitNo_d = bitNo_q;
      byte_d = byte_q;
      offset_d = offset_q;
      remain_d = remain_q;
      rdData_d = rdData_q;
      rdCount_d = rdCount_q;
      read_d = read_q;
      sclLow_d = sclLow_q;
      sdaLow_d = sdaLow_q;
      ackBad_d = ackBad_q;
      nack_d = nack_q;
      wrTake_d = 1'b0;
      rdValid_d = 1'b0;
      done_d = 1'b0;
      if (state_q == CFB_H_IDLE) begin
         div_d = 16'h0000;
         // A zero count is not a valid transfer and is never started.
         if (reqValid && reqCount != 8'h00) begin
            state_d = CFB_H_START;
            read_d = reqRead;
            offset_d = reqOffset;
            remain_d = reqCount;
            stage_d = 2'h0;
            phase_d = 2'h0;
            nack_d = 1'b0;
         end
      end else if (tick) begin
         phase_d = phase_q + 2'h1;
         case (phase_q)
            2'h0: begin
               sclLow_d = 1'b1;
               case (state_q)
                  CFB_H_SEND: sdaLow_d = bitNo_q < 4'h8 && !byte_q[7];
                  CFB_H_RECV: sdaLow_d = bitNo_q == 4'h8 && !lastByte;
                  CFB_H_STOP: sdaLow_d = 1'b1;
                  default: sdaLow_d = 1'b0;
               endcase
            end
            2'h1: sclLow_d = 1'b0;
            2'h2: begin
               case (state_q)
                  CFB_H_START: sdaLow_d = 1'b1;
                  CFB_H_STOP: sdaLow_d = 1'b0;
                  CFB_H_SEND: ackBad_d = bus.sda;
                  CFB_H_RECV: if (bitNo_q < 4'h8) byte_d = {byte_q[6:0], bus.sda};
                  default: ;
               endcase
            end
            default: begin
               sclLow_d = state_q != CFB_H_STOP;
               if ((state_q == CFB_H_SEND || state_q == CFB_H_RECV) && bitNo_q < 4'h8) begin
                  bitNo_d = bitNo_q + 4'h1;
                  if (state_q == CFB_H_SEND) byte_d = {byte_q[6:0], 1'b0};
               end else begin
                  bitNo_d = 4'h0;
                  state_d = CFB_H_SEND;
                  case (state_q)
                     CFB_H_START: byte_d = stage_q == 2'h0 ? CFB_ADDR_WRITE : CFB_ADDR_READ;
                     CFB_H_SEND: begin
                        if (ackBad_q) begin
                           state_d = CFB_H_STOP;
                           nack_d = 1'b1;
                        end else if (stage_q == 2'h0) begin
                           byte_d = offset_q;
                           stage_d = 2'h1;
                        end else if (stage_q == 2'h1) begin
                           stage_d = 2'h2;
                           if (read_q) state_d = CFB_H_START;
                           else byte_d = remain_q;
                        end else if (read_q) begin
                           // The count byte arrives first; the stage moves on once it is taken.
                           state_d = CFB_H_RECV;
                        end else if (stage_q == 2'h3 && remain_q == 8'h00) begin
                           state_d = CFB_H_STOP;
                        end else begin
                           byte_d = wrData;
                           wrTake_d = 1'b1;
                           remain_d = remain_q - 8'h01;
                           stage_d = 2'h3;
                        end
                     end
                     CFB_H_RECV: begin
                        state_d = CFB_H_RECV;
                        if (stage_q == 2'h2) begin
                           rdCount_d = byte_q;
                           stage_d = 2'h3;
                        end else begin
                           rdData_d = byte_q;
                           rdValid_d = 1'b1;
                           remain_d = remain_q - 8'h01;
                           if (remain_q == 8'h01) state_d = CFB_H_STOP;
                        end
                     end
                     default: begin
                        state_d = CFB_H_IDLE;
                        sclLow_d = 1'b0;
                        done_d = 1'b1;
                     end
                  endcase
               end
            end
         endcase
      end
      ready_d = state_d == CFB_H_IDLE;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= CFB_H_IDLE;
         div_q <= 16'h0000;
         phase_q <= 2'h0;
         stage_q <= 2'h0;
         bitNo_q <= 4'h0;
         byte_q <= 8'h00;
         offset_q <= 8'h00;
         remain_q <= 8'h00;
         rdData_q <= 8'h00;
         rdCount_q <= 8'h00;
         read_q <= 1'b0;
         sclLow_q <= 1'b0;
         sdaLow_q <= 1'b0;
         ackBad_q <= 1'b0;
         nack_q <= 1'b0;
         wrTake_q <= 1'b0;
         rdValid_q <= 1'b0;
         done_q <= 1'b0;
         ready_q <= 1'b1;
      end else begin
         state_q <= state_d;
         div_q <= div_d;
         phase_q <= phase_d;
         stage_q <= stage_d;
         bitNo_q <= bitNo_d;
         byte_q <= byte_d;
         offset_q <= offset_d;
         remain_q <= remain_d;
         rdData_q <= rdData_d;
         rdCount_q <= rdCount_d;
         read_q <= read_d;
         sclLow_q <= sclLow_d;
         sdaLow_q <= sdaLow_d;
         ackBad_q <= ackBad_d;
         nack_q <= nack_d;
         wrTake_q <= wrTake_d;
         rdValid_q <= rdValid_d;
         done_q <= done_d;
         ready_q <= ready_d;
      end
   end

   assign bus.sclHostOe = sclLow_q;
   assign bus.sclHostOut = 1'b0;
   assign bus.sdaHostOe = sdaLow_q;
   assign bus.sdaHostOut = 1'b0;
   assign reqReady = ready_q;
   assign wrTake = wrTake_q;
   assign rdData = rdData_q;
   assign rdValid = rdValid_q;
   assign rdCountByte = rdCount_q;
   assign nackSeen = nack_q;
   assign done = done_q;
endmodule
`default_nettype wire

/* File: tb/cfb_wire_props.sv */
`timescale 1ns/100ps
`default_nettype none
module cfb_wire_props (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclHostOe,
   input wire logic sdaHostOe,
   input wire logic sdaDevOe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // Longest legal pull by the device is its ack plus eight zero bits of sixteen cycles each.
   logic [8:0] devLowCnt_q;
   logic [8:0] devLowCnt_d;
   always_comb begin
      devLowCnt_d = sdaDevOe ? devLowCnt_q + 9'h001 : 9'h000;
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         devLowCnt_q <= 9'h000;
      end else begin
         devLowCnt_q <= devLowCnt_d;
      end
   end
   sequence stopCond;
      $rose(sda) && scl && $past(scl);
   endsequence
   a_dev_moves_low: assert property ($changed(sdaDevOe) |-> !scl)
      else $error("device moved data while clock high");
   a_dev_pull_bounded: assert property (devLowCnt_q <= 9'h090)
      else $error("device holds data line too long");
   a_stop_quiet: assert property (stopCond |-> !sdaDevOe [*8])
      else $error("device pulls data after stop");
   a_stop_by_host: assert property (stopCond |-> !sdaHostOe && !sclHostOe)
      else $error("stop not made by host release");
   a_start_by_host: assert property ($fell(sda) && scl && $past(scl) |-> sdaHostOe && !sdaDevOe)
      else $error("start not made by host");
   a_scl_high_min: assert property ($rose(scl) |-> scl [*4])
      else $error("clock high too short");
   a_scl_low_min: assert property ($fell(scl) |-> !scl [*4])
      else $error("clock low too short");
   a_reset_quiet: assert property ($rose(reset_n) |-> !sdaDevOe [*4])
      else $error("device pulls data after reset");
   cover property (stopCond);
   cover property ($rose(sdaDevOe));
   cover property (devLowCnt_q == 9'h050);
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb import cfb_pkg::*;;
   logic clk = 1'b0, reset_n = 1'b0, reqValid = 1'b0, reqRead = 1'b0;
   logic [7:0] reqOffset = 8'h00, reqCount = 8'h01, wrData = 8'h00, enPins = 8'hFF;
   logic strap = 1'b0, pdPin = 1'b1, haltIn = 1'b1, loopPin = 1'b1;
   logic bwN = 1'b1, halveN = 1'b1, locked = 1'b1;
   logic reqReady, wrTake, rdValid, nackSeen, done;
   logic [7:0] rdData, rdCountByte, pairDrive, pairRun, pllVec;
   logic pllRun, bwLow, halveRate, detectOn, lockOut;
   int errCount = 0, nTests = 0;
   logic [7:0] wbuf [8];
   logic [7:0] ebuf [8];
   assign pllVec = {3'h0, pllRun, detectOn, lockOut, bwLow, halveRate};
   cfb_smbus_if busIf ();
   cfb_smbus_host #(.QUARTER(4)) cfb_smbus_host_inst (.clk(clk), .reset_n(reset_n),
      .bus(busIf), .reqValid(reqValid), .reqRead(reqRead), .reqOffset(reqOffset),
      .reqCount(reqCount), .wrData(wrData), .reqReady(reqReady), .wrTake(wrTake),
      .rdData(rdData), .rdValid(rdValid), .rdCountByte(rdCountByte),
      .nackSeen(nackSeen), .done(done));
   cfb_smbus_device cfb_smbus_device_inst (.clk(clk), .reset_n(reset_n), .bus(busIf),
      .outputEnablePins(enPins), .enablePolarityStrap(strap), .powerDownPin(pdPin),
      .referenceHaltInput(haltIn), .loopSelectPin(loopPin), .loopBandwidthSelectN(bwN),
      .halveRateSelectN(halveN), .pllLockedIn(locked), .pairDrive(pairDrive),
      .pairRun(pairRun), .pllRun(pllRun), .pllBandwidthLow(bwLow), .halveRate(halveRate),
      .clockDetectOn(detectOn), .lockOut(lockOut));
   cfb_wire_props cfb_wire_props_inst (.clk(clk), .reset_n(reset_n),
      .sclHostOe(busIf.sclHostOe), .sdaHostOe(busIf.sdaHostOe), .sdaDevOe(busIf.sdaDevOe),
      .scl(busIf.scl), .sda(busIf.sda));
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
      nTests++;
      if (g !== e) begin
         errCount++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   // Called at a falling edge; the host is idle, so the request is taken at the next edge.
   task automatic xfer(input logic rd, input logic [7:0] ofs, input logic [7:0] n);
      int k, w;
      logic took;
      k = 0;
      w = 0;
      took = 1'b0;
      reqValid = 1'b1;
      reqRead = rd;
      reqOffset = ofs;
      reqCount = n;
      wrData = wbuf[0];
      @(negedge clk);
      reqValid = 1'b0;
      chk({7'h00, reqReady}, 8'h00, "ready while busy");
      for (int i = 0; i < 8000; i++) begin
         @(negedge clk);
         // The next byte is offered only once the take pulse is over.
         if (took && !wrTake && w < 7) begin
            w++;
            wrData = wbuf[w];
         end
         took = wrTake;
         if (rdValid === 1'b1) begin
            chk(rdData, ebuf[k[2:0]], "read byte");
            k++;
         end
         if (done === 1'b1) begin
            break;
         end
      end
      if (done !== 1'b1) begin
         errCount++;
         $display("[ERR] %0t transfer hung", $time);
         tally_and_finish();
      end
      chk({7'h00, reqReady}, 8'h01, "ready after done");
      chk({7'h00, nackSeen}, 8'h00, "byte refused");
      chk(k[7:0], rd ? n : 8'h00, "read byte count");
      if (rd) begin
         chk(rdCountByte, CFB_READ_COUNT, "count byte");
      end
   endtask
   task automatic t_defaults;
      ebuf = '{8'h07, 8'hFF, 8'h00, 8'h00, CFB_IDENT_DEFAULT, 8'h00, 8'h00, 8'h00};
      xfer(1'b1, 8'h00, 8'h06);
      $display("t_defaults done");
   endtask
   task automatic t_block;
      wbuf[0] = 8'hA5;
      wbuf[1] = 8'h55;
      xfer(1'b0, 8'h03, 8'h02);
      ebuf[0] = 8'hA5;
      ebuf[1] = CFB_IDENT_DEFAULT;
      xfer(1'b1, 8'h03, 8'h02);
      wbuf[0] = 8'h5A;
      xfer(1'b0, 8'h03, 8'h01);
      ebuf[0] = 8'h5A;
      xfer(1'b1, 8'h03, 8'h01);
      $display("t_block done");
   endtask
   task automatic t_pins;
      wbuf[0] = 8'h0F;
      wbuf[1] = 8'h3C;
      xfer(1'b0, 8'h01, 8'h02);
      enPins = 8'h55;
      for (int s = 0; s < 2; s++) begin
         strap = s[0];
         pdPin = ~s[0];
         haltIn = ~s[0];
         repeat (2) @(negedge clk);
         chk(pairDrive, s[0] ? 8'h0A : 8'h05, "pair drive");
         chk(pairRun, s[0] ? 8'h0A : 8'h05, "pair run");
      end
      strap = 1'b0;
      pdPin = 1'b1;
      haltIn = 1'b1;
      enPins = 8'hFF;
      $display("t_pins done");
   endtask
   task automatic t_loop;
      logic on, lp;
      for (int r = 0; r < 2; r++) begin
         on = (r == 0);
         for (int c = 0; c < 8; c++) begin
            loopPin = c[2];
            bwN = c[1];
            halveN = c[0];
            locked = c[0];
            repeat (2) @(negedge clk);
            lp = c[2] & on;
            chk(pllVec, {3'h0, lp, lp, lp & c[0], c[1] & on, ~(c[0] & on)}, "loop");
         end
         wbuf[0] = 8'h00;
         xfer(1'b0, 8'h00, 8'h01);
      end
      loopPin = 1'b1;
      bwN = 1'b1;
      halveN = 1'b1;
      locked = 1'b1;
      $display("t_loop done");
   endtask
   task automatic t_stop;
      haltIn = 1'b0;
      repeat (2) @(negedge clk);
      chk(pairRun, 8'h03, "halt run");
      chk(pairDrive, 8'h0F, "halt driven");
      wbuf[0] = 8'hC7;
      xfer(1'b0, 8'h00, 8'h01);
      chk(pairDrive, 8'h03, "halt tristate");
      haltIn = 1'b1;
      pdPin = 1'b0;
      repeat (2) @(negedge clk);
      chk(pairDrive, 8'h00, "down tristate");
      wbuf[0] = 8'h07;
      xfer(1'b0, 8'h00, 8'h01);
      chk(pairDrive, 8'h0F, "down driven");
      chk(pairRun, 8'h00, "down stopped");
      pdPin = 1'b1;
      $display("t_stop done");
   endtask
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      t_defaults();
      t_block();
      t_pins();
      t_loop();
      t_stop();
      tally_and_finish();
   end
endmodule
`default_nettype wire
